// ===== hdl/sst_core.v
// synchronous serial interface: clocking, bit order and transmit mode
`timescale 1ns/1ps
module sst_core
(
   input wire CLK,
   input wire RESET_N,
   input wire START_SET,
   input wire START_CLR,
   input wire FORCE_STOP_SET,
   input wire [1:0] XFER_MODE,
   input wire BIT_ORDER,
   input wire [2:0] CLK_SEL,
   input wire SLOW_SRC,
   input wire TX_WR,
   input wire [7:0] TX_DATA,
   input wire TX_ERR_CLR,
   input wire RX_ERR_CLR,
   input wire SERIAL_CLK_PIN_I,
   input wire SERIAL_IN_PIN,
   output reg SERIAL_CLK_PIN_O,
   output reg SERIAL_CLK_PIN_OE,
   output reg SERIAL_OUT_PIN,
   output reg START_CTL,
   output reg FORCE_STOP_CTL,
   output reg XFER_ACTIVE_FLAG,
   output reg PARTIAL_BYTE_FLAG,
   output reg TX_EMPTY_FLAG,
   output reg TX_ERROR_FLAG,
   output reg RX_ERROR_FLAG,
   output reg [7:0] RX_BUFFER,
   output reg SERIAL_IRQ
);
`include "sst_defines.vh"
   reg [7:0] tx_buf_r;
   reg [7:0] shift_r;
   reg [3:0] fall_cnt_r;
   reg loaded_r;
   reg irq_pend_r;
   reg sck_int_r;
   reg run_r;
   reg pin_s1_r;
   reg pin_s2_r;
   reg pin_d_r;
   reg [7:0] rx_shift_r;
   reg si_s1_r;
   reg si_s2_r;
   wire tick;
   wire ext_mode;
   wire tx_mode;
   wire ext_fall;
   wire ext_rise;
   wire int_fall;
   wire int_rise;
   wire fall;
   wire rise;
   wire out_bit;
   wire byte_done;

   assign ext_mode = (CLK_SEL == `SST_CLK_EXT);
   assign tx_mode = (XFER_MODE == `SST_MODE_TX);

   // two stage synchroniser then edge detect on the second stage
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         pin_s1_r <= 1'b1;
         pin_s2_r <= 1'b1;
         pin_d_r <= 1'b1;
         si_s1_r <= 1'b1;
         si_s2_r <= 1'b1;
      end
      else
      begin
         pin_s1_r <= SERIAL_CLK_PIN_I;
         pin_s2_r <= pin_s1_r;
         pin_d_r <= pin_s2_r;
         // data pin delayed like the clock so both line up at the sampling edge
         si_s1_r <= SERIAL_IN_PIN;
         si_s2_r <= si_s1_r;
      end
   end

   // external edges count on any change of the synchronised pin, with no check of pulse width
   assign ext_fall = ext_mode & pin_d_r & ~pin_s2_r;
   assign ext_rise = ext_mode & ~pin_d_r & pin_s2_r;

   sst_divider sst_divider_i
   (
      .CLK(CLK),
      .RESET_N(RESET_N),
      .run(run_r),
      .sel(CLK_SEL),
      .slow_src(SLOW_SRC),
      .tick(tick)
   );

   assign int_fall = ~ext_mode & tick & sck_int_r;
   assign int_rise = ~ext_mode & tick & ~sck_int_r;
   assign fall = ext_fall | int_fall;
   assign rise = ext_rise | int_rise;
   assign byte_done = (fall_cnt_r == 4'h8);
   // bit order picks which end leaves first
   assign out_bit = BIT_ORDER ? shift_r[0] : shift_r[7];

   // internal clock runs only while a byte is loaded, otherwise waits high
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         run_r <= 1'b0;
      end
      else if (FORCE_STOP_SET | ext_mode)
      begin
         run_r <= 1'b0;
      end
      else if (!run_r)
      begin
         // start only with data buffered, else auto-wait holds clock high
         run_r <= START_CTL & tx_mode & (~TX_EMPTY_FLAG | TX_WR);
      end
      else if (int_rise & byte_done & (TX_EMPTY_FLAG | ~START_CTL))
      begin
         run_r <= 1'b0;
      end
   end

   // control bits and buffer access
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         START_CTL <= 1'b0;
         FORCE_STOP_CTL <= 1'b0;
         tx_buf_r <= 8'h00;
         TX_EMPTY_FLAG <= 1'b1;
         TX_ERROR_FLAG <= 1'b0;
         RX_ERROR_FLAG <= 1'b0;
         RX_BUFFER <= 8'h00;
      end
      else if (FORCE_STOP_SET)
      begin
         START_CTL <= 1'b0;
         FORCE_STOP_CTL <= 1'b1;
         tx_buf_r <= 8'h00;
         TX_EMPTY_FLAG <= 1'b1;
         TX_ERROR_FLAG <= 1'b0;
         RX_ERROR_FLAG <= 1'b0;
         RX_BUFFER <= 8'h00;
      end
      else
      begin
         FORCE_STOP_CTL <= 1'b0;
         if (START_SET)
            START_CTL <= 1'b1;
         else if (START_CLR)
            START_CTL <= 1'b0;
         // buffer moves to the shift register on load; set wins over write
         if (TX_WR & TX_EMPTY_FLAG)
         begin
            tx_buf_r <= TX_DATA;
            TX_EMPTY_FLAG <= 1'b0;
         end
         // a write with the buffer full is simply ignored
         if (rise & loaded_r)
            TX_EMPTY_FLAG <= 1'b1;
         // error set wins over a same-cycle clear; writing one never sets
         if (fall & ext_mode & tx_mode & START_CTL & XFER_ACTIVE_FLAG & fall_cnt_r == 4'h8
             & TX_EMPTY_FLAG & ~(TX_WR))
            TX_ERROR_FLAG <= 1'b1;
         else if (fall & ext_mode & tx_mode & START_CTL & ~XFER_ACTIVE_FLAG & TX_EMPTY_FLAG
                  & ~TX_WR)
            TX_ERROR_FLAG <= 1'b1;
         else if (TX_ERR_CLR)
            TX_ERROR_FLAG <= 1'b0;
         if (RX_ERR_CLR)
            RX_ERROR_FLAG <= 1'b0;
         if (rise & ~tx_mode & fall_cnt_r == 4'h8)
            RX_BUFFER <= BIT_ORDER ? {si_s2_r, rx_shift_r[7:1]}
                         : {rx_shift_r[6:0], si_s2_r};
      end
   end

   // shift engine: load on falling edge, shift out on falling, sample on rising
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         shift_r <= 8'hFF;
         fall_cnt_r <= 4'h0;
         loaded_r <= 1'b0;
         XFER_ACTIVE_FLAG <= 1'b0;
         PARTIAL_BYTE_FLAG <= 1'b0;
         SERIAL_OUT_PIN <= 1'b1;
         irq_pend_r <= 1'b0;
         SERIAL_IRQ <= 1'b0;
         rx_shift_r <= 8'h00;
      end
      else if (FORCE_STOP_SET)
      begin
         shift_r <= 8'hFF;
         fall_cnt_r <= 4'h0;
         loaded_r <= 1'b0;
         XFER_ACTIVE_FLAG <= 1'b0;
         PARTIAL_BYTE_FLAG <= 1'b0;
         SERIAL_OUT_PIN <= 1'b1;
         irq_pend_r <= 1'b0;
         SERIAL_IRQ <= 1'b0;
         rx_shift_r <= 8'h00;
      end
      else
      begin
         SERIAL_IRQ <= 1'b0;
         if (rise)
         begin
            loaded_r <= 1'b0;
            if (loaded_r | TX_ERROR_FLAG)
               irq_pend_r <= 1'b1;
            rx_shift_r <= BIT_ORDER ? {si_s2_r, rx_shift_r[7:1]}
                          : {rx_shift_r[6:0], si_s2_r};
            if (byte_done & ~run_r & ~ext_mode)
               XFER_ACTIVE_FLAG <= 1'b0;
         end
         if (fall)
         begin
            if (irq_pend_r)
            begin
               SERIAL_IRQ <= 1'b1;
               irq_pend_r <= 1'b0;
            end
            if ((fall_cnt_r == 4'h0 | byte_done) & START_CTL & tx_mode)
            begin
               // new byte begins: back to back when buffered in time
               XFER_ACTIVE_FLAG <= 1'b1;
               PARTIAL_BYTE_FLAG <= 1'b1;
               fall_cnt_r <= 4'h1;
               if (!TX_EMPTY_FLAG)
               begin
                  shift_r <= BIT_ORDER ? {1'b1, tx_buf_r[7:1]} : {tx_buf_r[6:0], 1'b1};
                  SERIAL_OUT_PIN <= BIT_ORDER ? tx_buf_r[0] : tx_buf_r[7];
                  loaded_r <= 1'b1;
               end
               else
               begin
                  SERIAL_OUT_PIN <= 1'b1;
                  shift_r <= 8'hFF;
               end
            end
            else if (fall_cnt_r != 4'h0 & ~byte_done)
            begin
               fall_cnt_r <= fall_cnt_r + 4'h1;
               PARTIAL_BYTE_FLAG <= (fall_cnt_r != 4'h7);
               shift_r <= BIT_ORDER ? {1'b1, shift_r[7:1]} : {shift_r[6:0], 1'b1};
               SERIAL_OUT_PIN <= TX_ERROR_FLAG ? 1'b1 : out_bit;
            end
            else
            begin
               // start cleared: byte finished, stop and idle high
               fall_cnt_r <= 4'h0;
               XFER_ACTIVE_FLAG <= 1'b0;
               PARTIAL_BYTE_FLAG <= 1'b0;
               SERIAL_OUT_PIN <= 1'b1;
            end
         end
         if (TX_ERROR_FLAG)
            SERIAL_OUT_PIN <= 1'b1;
         if (~run_r & ~ext_mode & byte_done & ~START_CTL)
         begin
            fall_cnt_r <= 4'h0;
            XFER_ACTIVE_FLAG <= 1'b0;
            SERIAL_OUT_PIN <= 1'b1;
         end
      end
   end

   // internal serial clock toggles on divider ticks, parked high otherwise
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sck_int_r <= 1'b1;
         SERIAL_CLK_PIN_O <= 1'b1;
         SERIAL_CLK_PIN_OE <= 1'b0;
      end
      else
      begin
         if (!run_r)
            sck_int_r <= 1'b1;
         else if (tick)
            sck_int_r <= ~sck_int_r;
         SERIAL_CLK_PIN_O <= run_r & tick ? ~sck_int_r : (run_r ? sck_int_r : 1'b1);
         SERIAL_CLK_PIN_OE <= ~ext_mode;
      end
   end
endmodule // sst_core

// ===== hdl/sst_defines.vh
// constants for the synchronous serial transmit block
`ifndef SST_DEFINES_VH
`define SST_DEFINES_VH
`define SST_CLK_EXT 3'h7
`define SST_MODE_TX 2'h0
`define SST_MODE_RX 2'h1
`define SST_DIV_W 12
`define SST_FC_HZ 16000000
`define SST_CLK_HZ 125000000
`define SST_EXT_MIN_NS 250
`define SST_EXT_MIN_CYC ((`SST_EXT_MIN_NS * (`SST_CLK_HZ / 1000000) + 999) / 1000)
`endif

// ===== hdl/sst_divider.v
// serial clock divider: one-cycle half-period pulses at the selected rate
`timescale 1ns/1ps
module sst_divider
(
   input wire CLK,
   input wire RESET_N,
   input wire run,
   input wire [2:0] sel,
   input wire slow_src,
   output reg tick
);
`include "sst_defines.vh"
   reg [`SST_DIV_W-1:0] cnt_r;
   reg [3:0] expo;

   // half period of fc/2^n is 2^(n-1) input clocks
   always @*
   begin
      case (sel)
         3'h0: expo = slow_src ? 4'h5 : 4'hC;
         3'h1: expo = 4'h8;
         3'h2: expo = 4'h7;
         3'h3: expo = 4'h6;
         3'h4: expo = 4'h5;
         3'h5: expo = 4'h4;
         3'h6: expo = 4'h3;
         default: expo = 4'h3;
      endcase
   end

   // counter stops while idle so the first half period is full length
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         cnt_r <= {`SST_DIV_W{1'b0}};
         tick <= 1'b0;
      end
      else if (!run)
      begin
         cnt_r <= {`SST_DIV_W{1'b0}};
         tick <= 1'b0;
      end
      else if (cnt_r >= ((12'h001 << (expo - 4'h1)) - 12'h001))
      begin
         cnt_r <= {`SST_DIV_W{1'b0}};
         tick <= 1'b1;
      end
      else
      begin
         cnt_r <= cnt_r + 12'h001;
         tick <= 1'b0;
      end
   end
endmodule // sst_divider

// ===== tb/sst_core_assertions.sv
// port-level assertion checker for the serial transmit block
`timescale 1ns/1ps
module sst_core_assertions
(
   input wire CLK,
   input wire RESET_N,
   input wire FORCE_STOP_SET,
   input wire TX_WR,
   input wire TX_ERR_CLR,
   input wire [2:0] CLK_SEL,
   input wire SERIAL_CLK_PIN_O,
   input wire SERIAL_CLK_PIN_OE,
   input wire SERIAL_OUT_PIN,
   input wire START_CTL,
   input wire FORCE_STOP_CTL,
   input wire XFER_ACTIVE_FLAG,
   input wire PARTIAL_BYTE_FLAG,
   input wire TX_EMPTY_FLAG,
   input wire TX_ERROR_FLAG,
   input wire SERIAL_IRQ
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   // forced stop: request, then a one-cycle acknowledge that drops by itself
   sequence stop_req;
      FORCE_STOP_SET;
   endsequence
   sequence stop_ack;
      ##[0:1] FORCE_STOP_CTL ##1 !FORCE_STOP_CTL;
   endsequence
   ext_release_a: assert property ((CLK_SEL == 3'h7) [*2] |=> !SERIAL_CLK_PIN_OE)
      else $error("clock pin driven with external clock");
   int_drive_a: assert property ((CLK_SEL != 3'h7) [*2] |=> SERIAL_CLK_PIN_OE)
      else $error("clock pin not driven with internal clock");
   clk_idle_a: assert property (!XFER_ACTIVE_FLAG && SERIAL_CLK_PIN_OE |-> SERIAL_CLK_PIN_O)
      else $error("clock pin low while idle");
   empty_clear_a: assert property (TX_WR && TX_EMPTY_FLAG && !FORCE_STOP_SET |=> !TX_EMPTY_FLAG)
      else $error("empty flag stayed set after write");
   err_out_a: assert property (TX_ERROR_FLAG && $past(TX_ERROR_FLAG) |-> SERIAL_OUT_PIN)
      else $error("data out low during error");
   err_hold_a: assert property (TX_ERROR_FLAG && !TX_ERR_CLR && !FORCE_STOP_SET |=> TX_ERROR_FLAG)
      else $error("error flag cleared without cause");
   stop_done_a: assert property (stop_req |-> stop_ack)
      else $error("forced stop control did not clear");
   stop_init_a: assert property (stop_req |=> !START_CTL && !XFER_ACTIVE_FLAG && TX_EMPTY_FLAG
      && !TX_ERROR_FLAG)
      else $error("forced stop left state set");
   partial_xfer_a: assert property (PARTIAL_BYTE_FLAG |-> XFER_ACTIVE_FLAG)
      else $error("partial byte flag outside transfer");
   irq_pulse_a: assert property (SERIAL_IRQ |=> !SERIAL_IRQ)
      else $error("interrupt longer than one cycle");
endmodule // sst_core_assertions
bind sst_core sst_core_assertions sst_core_assertions_i (.*);

// ===== tb/sst_core_tb.sv
// self-checking bench for the serial transmit block
`timescale 1ns/1ps
`include "sst_defines.vh"
module sst_core_tb;
   reg CLK = 1'b0;
   reg RESET_N = 1'b0;
   reg START_SET = 1'b0;
   reg START_CLR = 1'b0;
   reg FORCE_STOP_SET = 1'b0;
   reg BIT_ORDER = 1'b0;
   reg [2:0] CLK_SEL = 3'h6;
   reg TX_WR = 1'b0;
   reg [7:0] TX_DATA = 8'h00;
   reg TX_ERR_CLR = 1'b0;
   reg ext_run = 1'b0;
   wire sck_o, sck_oe, so, si, ext_sck, sck, active, partial, empty, terr, start, irq;
   wire [7:0] pbyte;
   wire [31:0] pb;
   integer error_cnt = 0;
   integer total_checks = 0;
   integer irq_cnt = 0;
   // the pin carries the device driver when enabled, else the far side
   assign sck = sck_oe ? sck_o : ext_sck;
   // interrupt pulses counted here so scenarios can compare totals
   always @(posedge CLK)
   begin
      if (irq === 1'b1)
         irq_cnt <= irq_cnt + 1;
   end
   initial
   begin
      forever #4 CLK = ~CLK;
   end
   sst_core sst_core_i (.CLK(CLK), .RESET_N(RESET_N), .START_SET(START_SET),
      .START_CLR(START_CLR), .FORCE_STOP_SET(FORCE_STOP_SET), .XFER_MODE(`SST_MODE_TX),
      .BIT_ORDER(BIT_ORDER), .CLK_SEL(CLK_SEL), .SLOW_SRC(1'b0), .TX_WR(TX_WR),
      .TX_DATA(TX_DATA), .TX_ERR_CLR(TX_ERR_CLR), .RX_ERR_CLR(1'b0), .SERIAL_CLK_PIN_I(sck),
      .SERIAL_IN_PIN(si), .SERIAL_CLK_PIN_O(sck_o), .SERIAL_CLK_PIN_OE(sck_oe),
      .SERIAL_OUT_PIN(so), .START_CTL(start), .FORCE_STOP_CTL(), .XFER_ACTIVE_FLAG(active),
      .PARTIAL_BYTE_FLAG(partial), .TX_EMPTY_FLAG(empty), .TX_ERROR_FLAG(terr),
      .RX_ERROR_FLAG(), .RX_BUFFER(), .SERIAL_IRQ(irq));
   sst_peer sst_peer_i (.clk(CLK), .sck(sck), .so(so), .ext_run(ext_run),
      .ext_sck(ext_sck), .si(si), .rx_byte(pbyte), .rx_bits(pb));
   task conclude;
   begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   task chk(input string nm, input [7:0] e, input [7:0] g);
   begin
      total_checks = total_checks + 1;
      if (g !== e)
      begin
         error_cnt = error_cnt + 1;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   end
   endtask
   // one-cycle control pulse: 0 start, 1 stop, 2 forced stop, 3 error clear
   task pl(input integer w);
   begin
      @(posedge CLK);
      case (w)
         0: START_SET <= 1'b1;
         1: START_CLR <= 1'b1;
         2: FORCE_STOP_SET <= 1'b1;
         default: TX_ERR_CLR <= 1'b1;
      endcase
      @(posedge CLK);
      {START_SET, START_CLR, FORCE_STOP_SET, TX_ERR_CLR} <= 4'h0;
   end
   endtask
   task wr(input [7:0] d);
   begin
      @(posedge CLK);
      TX_WR <= 1'b1;
      TX_DATA <= d;
      @(posedge CLK);
      TX_WR <= 1'b0;
   end
   endtask
   // bounded wait: 0 idle, 1 buffer empty, 2 error, 3 peer bit count reached
   task wt(input integer c, input integer n);
      integer k;
   begin
      k = 0;
      while (!(c == 0 ? active === 1'b0 : c == 1 ? empty === 1'b1 :
         c == 2 ? terr === 1'b1 : pb >= n) && k < 30000)
      begin
         @(posedge CLK);
         k = k + 1;
      end
      if (k == 30000)
      begin
         error_cnt = error_cnt + 1;
         $display("Error wait %0d expected done seen timeout", c);
         conclude;
      end
   end
   endtask
   function [7:0] rv(input o, input [7:0] d);
      integer i;
   begin
      for (i = 0; i < 8; i = i + 1)
         rv[i] = o ? d[7 - i] : d[i];
   end
   endfunction
   task t_reset;
   begin
      #1 chk("empty at reset", 8'h01, {7'h0, empty});
      chk("out at reset", 8'h01, {7'h0, so});
      chk("active at reset", 8'h00, {7'h0, active});
      $display("test reset done");
   end
   endtask
   // refused write, queued second byte, stop request during the second byte
   task t_tx(input o, input [7:0] a, input [7:0] c);
      integer b, n, k, i;
   begin
      @(posedge CLK);
      BIT_ORDER <= o;
      b = pb;
      i = irq_cnt;
      wr(a);
      #1 chk("empty after write", 8'h00, {7'h0, empty});
      wr(~a);
      pl(0);
      wt(1, 0);
      wr(c);
      wt(3, b + 8);
      chk("first byte", rv(o, a), pbyte);
      wt(3, pb + 1);
      n = pb;
      k = 0;
      while (pb == n && k < 100)
      begin
         @(posedge CLK);
         k = k + 1;
      end
      chk("clock period", 8'h08, k[7:0]);
      wt(3, b + 9);
      chk("partial in byte", 8'h01, {7'h0, partial});
      pl(1);
      wt(3, b + 16);
      chk("second byte", rv(o, c), pbyte);
      wt(0, 0);
      repeat (200) @(posedge CLK);
      chk("bits sent", 8'h10, pb[7:0] - b[7:0]);
      chk("out after stop", 8'h01, {7'h0, so});
      chk("clock after stop", 8'h01, {7'h0, sck});
      chk("partial after stop", 8'h00, {7'h0, partial});
      chk("irq pulses", 8'h02, irq_cnt[7:0] - i[7:0]);
      $display("test transmit order %0d done", o);
   end
   endtask
   // external clock with no data buffered: underrun, stop and recovery
   task t_ext;
      integer i;
   begin
      @(posedge CLK);
      CLK_SEL <= `SST_CLK_EXT;
      repeat (3) @(posedge CLK);
      chk("pin enable", 8'h00, {7'h0, sck_oe});
      pl(0);
      ext_run <= 1'b1;
      wt(2, 0);
      #1 chk("out in error", 8'h01, {7'h0, so});
      i = irq_cnt;
      wt(3, pb + 2);
      chk("irq after error", 8'h01, irq_cnt[7:0] - i[7:0]);
      pl(1);
      #1 chk("error after stop", 8'h01, {7'h0, terr});
      ext_run <= 1'b0;
      pl(3);
      #1 chk("error after clear", 8'h00, {7'h0, terr});
      pl(0);
      pl(2);
      #1 chk("start after forced", 8'h00, {7'h0, start});
      chk("empty after forced", 8'h01, {7'h0, empty});
      chk("active after forced", 8'h00, {7'h0, active});
      $display("test external done");
   end
   endtask
   initial
   begin
      repeat (8) @(posedge CLK);
      RESET_N <= 1'b1;
      @(posedge CLK);
      t_reset;
      t_tx(1'b0, 8'hA5, 8'h3C);
      t_tx(1'b1, 8'h96, 8'hC1);
      t_ext;
      conclude;
   end
endmodule // sst_core_tb

// ===== tb/sst_peer.sv
// far-side serial device: captures sent bits, makes an external clock on demand
`timescale 1ns/1ps
module sst_peer
(
   input wire clk,
   input wire sck,
   input wire so,
   input wire ext_run,
   output reg ext_sck = 1'b1,
   output reg si = 1'b1,
   output reg [7:0] rx_byte = 8'h00,
   output reg [31:0] rx_bits = 32'h0
);
   integer ph = 0;
   // half period of 40 cycles keeps both phases above the minimum; idle high between frames
   always @(posedge clk)
   begin
      ph <= ext_run ? (ph == 39 ? 0 : ph + 1) : 0;
      ext_sck <= ext_run ? (ph == 39 ? ~ext_sck : ext_sck) : 1'b1;
   end
   // sample on the rising pin edge, as the device shifts on the falling one
   always @(posedge sck)
   begin
      rx_byte <= {rx_byte[6:0], so};
      rx_bits <= rx_bits + 1;
   end
   // input line keeps changing so a stale value is never mistaken for data
   always @(negedge sck)
      si <= ~si;
endmodule // sst_peer
